// ==== mcr_pkg.sv ====
// Package with register map, field positions and counts of the clock controller
package mcr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_STATUS_IDX = 8'h2E;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h40;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h41;
  localparam logic [7:0] MODE_CTRL_IDX = 8'h42;
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CLK_OUT_BIT = 7;
  localparam int SLOW_DIV_LSB = 5;
  localparam int SLOW_SEL_BIT = 4;
  localparam int TB_SEL_LSB = 2;
  localparam int TB_IRQ_EN_BIT = 1;
  localparam int TB_IRQ_FLAG_BIT = 0;

  // ****************************************
  // Time-base periods in osc clock cycles
  // ****************************************
  localparam logic [17:0] TB_PERIOD_0 = 18'h03E80;
  localparam logic [17:0] TB_PERIOD_1 = 18'h07D00;
  localparam logic [17:0] TB_PERIOD_2 = 18'h13880;
  localparam logic [17:0] TB_PERIOD_3 = 18'h30D40;
  localparam logic [3:0] SLOW_DIV_RESET = 4'h0;
  localparam logic [17:0] TB_COUNT_RESET = 18'h00000;

  // Power modes driven by the core
  typedef enum logic [1:0] {
    MCR_RUN = 2'b00,
    MCR_WAIT = 2'b01,
    MCR_ACTIVE_HALT = 2'b11,
    MCR_HALT = 2'b10
  } mcr_power_t;

  // Control fields of the control/status register
  typedef struct packed {
    logic clock_out_enable;
    logic [1:0] slow_divider_select;
    logic slow_speed_select;
    logic [1:0] timebase_select;
    logic timebase_irq_enable;
  } mcr_ctrl_t;

endpackage

// ==== mcr_clock_ctrl.sv ====
// Main clock controller with CPU prescaler, clock-out and time-base counter
`timescale 1ns/1ns
module mcr_clock_ctrl (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Core power mode requests
  input wire logic halt_req_in,
  input wire logic wait_req_in,
  input wire logic wakeup_in,
  output mcr_pkg::mcr_power_t power_mode_out,
  output logic tb_wakeup_out,
  // Clocks and pin
  output logic cpu_clk_en_out,
  output logic clk_out_pin_out,
  output logic clk_out_oe_n_out,
  // Interrupts
  output logic tb_irq_out,
  output logic irq_out
);

  // ****************************************
  // State
  // ****************************************
  mcr_pkg::mcr_ctrl_t ctrl_reg;
  logic flag_reg;
  logic [17:0] tb_count_reg;
  logic [17:0] tb_count_next;
  logic [1:0] tb_active_sel_reg;
  logic [3:0] slow_count_reg;
  logic [3:0] slow_count_next;
  logic osc_half_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_status_next;
  logic ack_reg;
  logic [31:0] rdata_reg;
  mcr_pkg::mcr_power_t power_reg;
  mcr_pkg::mcr_power_t power_next;

  // Period length per selection code
  function automatic logic [17:0] tb_period(input logic [1:0] sel);
    unique case (sel)
      2'b00: tb_period = mcr_pkg::TB_PERIOD_0;
      2'b01: tb_period = mcr_pkg::TB_PERIOD_1;
      2'b10: tb_period = mcr_pkg::TB_PERIOD_2;
      2'b11: tb_period = mcr_pkg::TB_PERIOD_3;
    endcase
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  wire bus_req = wb_cyc_in && wb_stb_in && !ack_reg;
  wire bus_wr = bus_req && wb_we_in && wb_sel_in[0];
  wire bus_rd = bus_req && !wb_we_in;
  wire hit_csr = (wb_adr_in == {mcr_pkg::CTRL_STATUS_IDX[5:0], 2'b00});
  wire hit_ists = (wb_adr_in == {mcr_pkg::IRQ_STATUS_IDX[5:0], 2'b00});
  wire hit_imsk = (wb_adr_in == {mcr_pkg::IRQ_MASK_IDX[5:0], 2'b00});
  wire hit_mode = (wb_adr_in == {mcr_pkg::MODE_CTRL_IDX[5:0], 2'b00});
  wire frozen = (power_reg == mcr_pkg::MCR_HALT) || (power_reg == mcr_pkg::MCR_ACTIVE_HALT);
  wire [7:0] csr_value = {ctrl_reg, flag_reg};
  wire [31:0] rdata_mux = hit_csr ? {24'h000000, csr_value} :
                          hit_ists ? {30'h00000000, irq_status_reg} :
                          hit_imsk ? {30'h00000000, irq_mask_reg} :
                          hit_mode ? {30'h00000000, power_reg} : 32'h00000000;

  // ****************************************
  // Time-base counter
  // ****************************************
  wire counter_runs = (power_reg != mcr_pkg::MCR_HALT);
  wire period_end = counter_runs && (tb_count_reg == tb_period(tb_active_sel_reg) - 18'h00001);
  wire csr_read_clear = bus_rd && hit_csr;
  wire flag_next = period_end ? 1'b1 : (csr_read_clear ? 1'b0 : flag_reg);
  always_comb
  begin
    tb_count_next = tb_count_reg;
    if (period_end)
    begin
      tb_count_next = mcr_pkg::TB_COUNT_RESET;
    end
    else if (counter_runs)
    begin
      tb_count_next = tb_count_reg + 18'h00001;
    end
  end

  // Counter advances every cycle except in halt, selection latched only at period end
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tb_count_reg <= mcr_pkg::TB_COUNT_RESET;
      tb_active_sel_reg <= 2'b00;
    end
    else
    begin
      tb_count_reg <= tb_count_next;
      if (period_end)
      begin
        tb_active_sel_reg <= ctrl_reg.timebase_select;
      end
    end
  end

  // ****************************************
  // CPU clock prescaler
  // ****************************************
  wire [3:0] slow_last = ({3'b000, 1'b1} << ctrl_reg.slow_divider_select) * 4'h2 - 4'h1;
  always_comb
  begin
    slow_count_next = slow_count_reg + 4'h1;
    if (!ctrl_reg.slow_speed_select || slow_count_reg >= slow_last)
    begin
      slow_count_next = mcr_pkg::SLOW_DIV_RESET;
    end
  end
  assign cpu_clk_en_out = !frozen && (!ctrl_reg.slow_speed_select || slow_count_reg == slow_last);

  // Prescaler count and osc clock image
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      slow_count_reg <= mcr_pkg::SLOW_DIV_RESET;
      osc_half_reg <= 1'b0;
    end
    else
    begin
      slow_count_reg <= slow_count_next;
      osc_half_reg <= !osc_half_reg;
    end
  end

  // Clock-out pin, driven while enabled
  assign clk_out_pin_out = osc_half_reg && ctrl_reg.clock_out_enable;
  assign clk_out_oe_n_out = !ctrl_reg.clock_out_enable;

  // ****************************************
  // Power mode
  // ****************************************
  always_comb
  begin
    power_next = power_reg;
    unique case (power_reg)
      mcr_pkg::MCR_RUN:
      begin
        if (halt_req_in)
        begin
          power_next = ctrl_reg.timebase_irq_enable ? mcr_pkg::MCR_ACTIVE_HALT : mcr_pkg::MCR_HALT;
        end
        else if (wait_req_in)
        begin
          power_next = mcr_pkg::MCR_WAIT;
        end
      end
      mcr_pkg::MCR_WAIT:
      begin
        if (tb_irq_out || wakeup_in)
        begin
          power_next = mcr_pkg::MCR_RUN;
        end
      end
      mcr_pkg::MCR_ACTIVE_HALT:
      begin
        if (tb_irq_out || wakeup_in)
        begin
          power_next = mcr_pkg::MCR_RUN;
        end
      end
      mcr_pkg::MCR_HALT:
      begin
        if (wakeup_in)
        begin
          power_next = mcr_pkg::MCR_RUN;
        end
      end
    endcase
  end
  assign power_mode_out = power_reg;
  assign tb_wakeup_out = tb_irq_out && (power_reg == mcr_pkg::MCR_WAIT || power_reg == mcr_pkg::MCR_ACTIVE_HALT);

  // ****************************************
  // Registers and bus answer
  // ****************************************
  assign irq_status_next = (irq_status_reg & ~((bus_wr && hit_ists) ? wb_dat_in[1:0] : 2'b00))
                           | {tb_wakeup_out, period_end};
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_reg <= mcr_ctrl_reset();
      flag_reg <= mcr_pkg::CTRL_STATUS_RESET[mcr_pkg::TB_IRQ_FLAG_BIT];
      irq_status_reg <= 2'b00;
      irq_mask_reg <= 2'b00;
      power_reg <= mcr_pkg::MCR_RUN;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= bus_req;
      rdata_reg <= bus_rd ? rdata_mux : 32'h00000000;
      power_reg <= power_next;
      flag_reg <= flag_next;
      irq_status_reg <= irq_status_next;
      if (bus_wr && hit_csr && !frozen)
      begin
        ctrl_reg <= wb_dat_in[7:1];
      end
      if (bus_wr && hit_imsk)
      begin
        irq_mask_reg <= wb_dat_in[1:0];
      end
    end
  end

  // Reset image of the control fields
  function automatic mcr_pkg::mcr_ctrl_t mcr_ctrl_reset();
    mcr_ctrl_reset = mcr_pkg::CTRL_STATUS_RESET[7:1];
  endfunction

  // Outputs
  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdata_reg;
  assign tb_irq_out = flag_reg && ctrl_reg.timebase_irq_enable;
  assign irq_out = |(irq_status_reg & irq_mask_reg);

endmodule

// ==== mcr_checker.sv ====
// Port checker of the clock controller, bound to its top module
`timescale 1ns/1ns
module mcr_checker (
  // Watched ports
  input wire logic ref_clk_in, rst_in, wb_cyc_in, wb_stb_in, wb_ack_out, wakeup_in,
  input wire logic tb_wakeup_out, cpu_clk_en_out, clk_out_pin_out, clk_out_oe_n_out,
  input wire logic [31:0] wb_dat_out,
  input wire mcr_pkg::mcr_power_t power_mode_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // High in halt and active-halt alike
  wire halted = power_mode_out[1];
  a_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  a_upper_zero: assert property (wb_dat_out[31:8] == 24'h000000) else $error("upper read bits set");
  a_pin_idle: assert property (clk_out_oe_n_out |-> !clk_out_pin_out) else $error("pin driven");
  a_pin_toggle: assert property (!clk_out_oe_n_out && $past(!clk_out_oe_n_out) |->
    clk_out_pin_out != $past(clk_out_pin_out)) else $error("pin not toggling");
  a_halt_clk: assert property (halted |-> !cpu_clk_en_out) else $error("cpu clock in halt");
  a_halt_no_tb: assert property (power_mode_out == mcr_pkg::MCR_HALT |-> !tb_wakeup_out)
    else $error("time base wakes halt");
  a_tb_exit: assert property (tb_wakeup_out |-> ##[1:2] power_mode_out == mcr_pkg::MCR_RUN)
    else $error("no exit on time base");
  a_wake_exit: assert property (wakeup_in && halted |-> ##[1:2] power_mode_out == mcr_pkg::MCR_RUN)
    else $error("no exit on wakeup");
  c_active: cover property (power_mode_out == mcr_pkg::MCR_ACTIVE_HALT);
  c_halt: cover property (power_mode_out == mcr_pkg::MCR_HALT);
  c_tb_wake: cover property (tb_wakeup_out);
endmodule
bind mcr_clock_ctrl mcr_checker chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .wakeup_in(wakeup_in), .tb_wakeup_out(tb_wakeup_out),
  .cpu_clk_en_out(cpu_clk_en_out), .clk_out_pin_out(clk_out_pin_out), .clk_out_oe_n_out(clk_out_oe_n_out),
  .wb_dat_out(wb_dat_out), .power_mode_out(power_mode_out));

// ==== mcr_load_model.sv ====
// Clock-out load and core clock observer
`timescale 1ns/1ns
module mcr_load_model (
  input wire logic ref_clk_in, clr_in, cpu_clk_en_in, pin_in, oe_n_in,
  output int en_cnt, edge_cnt
);
  // Released pin sits at the pull-up level
  wire pin_w = oe_n_in ? 1'b1 : pin_in;
  logic last_w = 1'b1;
  // Count core clock enables and pin rises
  always @(posedge ref_clk_in)
  begin
    last_w <= pin_w;
    en_cnt <= clr_in ? 0 : en_cnt + cpu_clk_en_in;
    edge_cnt <= clr_in ? 0 : edge_cnt + (pin_w && !last_w);
  end
endmodule

// ==== mcr_clock_ctrl_bench.sv ====
// Self-checking bench of the clock controller
`timescale 1ns/1ns
module mcr_clock_ctrl_bench;
  logic ref_clk_in = 0, rst_in = 1, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0, clr = 0;
  logic halt_req_in = 0, wait_req_in = 0, wakeup_in = 0;
  logic [7:0] wb_adr_in = 8'h00, q;
  logic [3:0] wb_sel_in = 4'h1;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, r;
  logic wb_ack_out, tb_wakeup_out, cpu_clk_en_out, clk_out_pin_out, clk_out_oe_n_out, tb_irq_out, irq_out;
  mcr_pkg::mcr_power_t power_mode_out;
  int n_fail = 0, cmp_count = 0, seed = 35830, t0, t1, t2, i, c, en_cnt, edge_cnt, csr_m;
  mcr_clock_ctrl DUT (.*);
  mcr_load_model load (.ref_clk_in, .clr_in(clr), .cpu_clk_en_in(cpu_clk_en_out), .pin_in(clk_out_pin_out),
    .oe_n_in(clk_out_oe_n_out), .en_cnt, .edge_cnt);
  always #5 ref_clk_in = ~ref_clk_in;
  task chk(input logic [31:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Whole-byte bus cycle, never a read-modify-write of single bits
  task wb(input logic w, input logic [7:0] a, d);
    i = 0;
    @(posedge ref_clk_in);
    wb_cyc_in <= 1;
    wb_stb_in <= 1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= {24'h000000, d};
    @(posedge ref_clk_in);
    while (wb_ack_out !== 1'b1 && i < 50)
    begin
      i++;
      @(posedge ref_clk_in);
    end
    if (i >= 50)
      n_fail++;
    q = wb_dat_out[7:0];
    wb_cyc_in <= 0;
    wb_stb_in <= 0;
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // One-cycle request pulse: 0 halt, 1 wakeup, 2 wait
  task pulse(input int k);
    tick(1);
    if (k == 0)
      halt_req_in <= 1;
    else if (k == 1)
      wakeup_in <= 1;
    else
      wait_req_in <= 1;
    tick(1);
    halt_req_in <= 0;
    wakeup_in <= 0;
    wait_req_in <= 0;
    tick(1);
  endtask
  task wait_irq(output int t);
    i = 0;
    while (tb_irq_out !== 1'b1 && i < 40000)
    begin
      i++;
      tick(1);
    end
    if (i >= 40000)
      n_fail++;
    t = int'($time / 10);
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    #700000;
    n_fail++;
    stop_test;
  end
  // Main sequence
  initial
  begin
    tick(16);
    rst_in <= 0;
    t0 = int'($time / 10);
    wb(0, 8'hB8, 8'h00);
    chk(q, 8'h00, "reset csr");
    r = $random(seed);
    wb(1, 8'hFC, r[7:0]);
    wb(0, 8'hFC, 8'h00);
    chk(q, 8'h00, "unmapped");
    for (c = 0; c < 5; c++)
    begin
      wb(1, 8'hB8, c < 4 ? {1'b0, c[1:0], 1'b1, 4'h0} : 8'h80);
      clr <= 1;
      tick(1);
      clr <= 0;
      tick(65);
      chk(en_cnt, c < 4 ? 64 >> (c + 1) : 64, "cpu enables");
      chk(edge_cnt, c < 4 ? 0 : 32, "pin rises");
      chk(clk_out_oe_n_out, c < 4, "pin enable");
    end
    csr_m = 8'h06;
    wb(1, 8'hB8, csr_m[7:0]);
    wait_irq(t1);
    chk(t1 - t0 >= 16000 && t1 - t0 <= 16002, 1, "first period");
    chk(irq_out, 0, "masked irq");
    wb(1, 8'h04, 8'h01);
    tick(1);
    chk(irq_out, 1, "unmasked irq");
    wb(1, 8'h00, 8'h01);
    tick(1);
    chk(irq_out, 0, "cleared irq");
    wb(0, 8'hB8, 8'h00);
    chk(q, csr_m | 1, "flag read");
    tick(1);
    chk(tb_irq_out, 0, "irq after read");
    wb(0, 8'hB8, 8'h00);
    chk(q, csr_m, "flag cleared");
    pulse(0);
    chk(power_mode_out, mcr_pkg::MCR_ACTIVE_HALT, "active halt");
    wb(1, 8'hB8, 8'h00);
    wait_irq(t2);
    chk(t2 - t1, 32000, "second period");
    tick(3);
    chk(power_mode_out, mcr_pkg::MCR_RUN, "woken");
    wb(0, 8'hB8, 8'h00);
    chk(q, csr_m | 1, "frozen csr");
    wb(1, 8'hB8, 8'h04);
    pulse(0);
    tick(20);
    chk(power_mode_out, mcr_pkg::MCR_HALT, "full halt");
    pulse(1);
    tick(2);
    chk(power_mode_out, mcr_pkg::MCR_RUN, "halt exit");
    pulse(2);
    chk(power_mode_out, mcr_pkg::MCR_WAIT, "wait");
    stop_test;
  end
endmodule
